//--- core/pwsd_consts.svh
// named offsets, fields, reset values and timing counts of the shutdown block
`ifndef PWSD_CONSTS_SVH
`define PWSD_CONSTS_SVH

// register byte addresses
`define PWSD_ADDR_W 8
`define PWSD_OFS_ASD 8'h00
`define PWSD_OFS_RDB 8'h04
`define PWSD_OFS_UNIT 8'h08
`define PWSD_OFS_STEER 8'h0C
`define PWSD_OFS_AUX 8'h10

// auto_shutdown_control fields
`define PWSD_ASD_FLAG 7
`define PWSD_ASD_SRC_HI 6
`define PWSD_ASD_SRC_LO 4
`define PWSD_ASD_AC_HI 3
`define PWSD_ASD_AC_LO 2
`define PWSD_ASD_BD_HI 1
`define PWSD_ASD_BD_LO 0

// restart_deadband_control fields
`define PWSD_RDB_ARST 7
`define PWSD_RDB_DB_HI 6
`define PWSD_RDB_DB_LO 0

// unit_control fields
`define PWSD_UNIT_CFG_HI 7
`define PWSD_UNIT_CFG_LO 6
`define PWSD_UNIT_MODE_HI 3
`define PWSD_UNIT_MODE_LO 0
`define PWSD_MODE_PWM 2'h3

// steering_control and aux fields
`define PWSD_STEER_HI 3
`define PWSD_STEER_LO 0
`define PWSD_AUX_SYNC 0
`define PWSD_AUX_COND 8
`define PWSD_AUX_RUN 9

// reset values
`define PWSD_RST_ASD 7'h00
`define PWSD_RST_FLAG 1'b0
`define PWSD_RST_RDB 8'h00
`define PWSD_RST_UNIT 8'h00
`define PWSD_RST_STEER 4'h1
`define PWSD_RST_AUX 1'b0

// timing: one instruction cycle is four oscillator periods
`define PWSD_CLK_NS 10
`define PWSD_TOSC_NS 10
`define PWSD_TCY_TOSC 4
`define PWSD_TCY_CYC ((`PWSD_TCY_TOSC * `PWSD_TOSC_NS) / `PWSD_CLK_NS)

// bus answers
`define PWSD_RESP_OKAY 2'h0
`define PWSD_RESP_SLVERR 2'h2

`endif

//--- core/pwsd_pkg.sv
// types shared by the shutdown, dead-band and steering logic
package pwsd_pkg;

  // output configuration field
  typedef enum logic [1:0] {
    PWSD_CFG_SINGLE,
    PWSD_CFG_FWD,
    PWSD_CFG_HALF,
    PWSD_CFG_REV
  } pwsd_cfg_t;

  // output run state
  typedef enum logic {
    PWSD_RUN,
    PWSD_SHUT
  } pwsd_run_t;

  // shutdown sources from the pins and comparators
  typedef struct packed {
    logic cmp1Out;
    logic cmp2Out;
    logic faultPinN;
    logic t1Tick;
  } pwsd_src_t;

  // four output pins with their enables
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } pwsd_pins_t;

endpackage

//--- core/pwsd_deadband.sv
// dead-band delay on the rising edge of one half-bridge output
`include "pwsd_consts.svh"

module pwsd_deadband import pwsd_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // timing
  input wire logic tcyEn,
  input wire logic [6:0] delayCount,
  // waveform
  input wire logic sigIn,
  output logic sigOut
);

  logic [6:0] cntReg;

  // a falling input drops the output at once, no delay
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cntReg <= 7'h00;
      sigOut <= 1'b0;
    end else if (!sigIn) begin
      cntReg <= 7'h00;
      sigOut <= 1'b0;
    end else if (!sigOut) begin
      if (cntReg >= delayCount) begin
        sigOut <= 1'b1;
      end else if (tcyEn) begin
        cntReg <= cntReg + 7'h01;
      end
    end
  end

endmodule

//--- core/pwsd_top.sv
// auto-shutdown, dead-band and pulse steering of the enhanced pwm outputs
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`include "pwsd_consts.svh"

module pwsd_top import pwsd_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`PWSD_ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`PWSD_ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // pwm waveform from the period/duty logic
  input wire logic pwmIn,
  input wire logic periodStart,
  // shutdown sources
  input pwsd_src_t src,
  // output pins
  output pwsd_pins_t pins
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic addrHit(input logic [`PWSD_ADDR_W-1:0] a);
    addrHit = (a == `PWSD_OFS_ASD) || (a == `PWSD_OFS_RDB) ||
              (a == `PWSD_OFS_UNIT) || (a == `PWSD_OFS_STEER) ||
              (a == `PWSD_OFS_AUX);
  endfunction

  // each source bit ors in one cause, so 011, 101, 110, 111 combine
  function automatic logic srcCond(input logic [2:0] sel, input logic c1,
                                   input logic c2, input logic pinLow);
    srcCond = (sel[0] & c1) | (sel[1] & c2) | (sel[2] & pinLow);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [6:0] asdReg;
  logic flagReg;
  logic [7:0] rdbReg;
  logic [7:0] unitReg;
  logic [3:0] steerReg;
  logic syncReg;
  logic cmp2SampReg;
  logic [1:0] divReg;
  logic [3:0] lvlReg;
  pwsd_run_t runReg;

  logic awHeld, wHeld, wrFire, wrHit, arFire;
  logic [`PWSD_ADDR_W-1:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;

  logic tcyEn, cmp2Eff, cond, forceNow, pwmOn, dbA, dbB;
  pwsd_cfg_t cfg;
  logic [3:0] polVec, actVec, enVec, safeLvl, safeZ;

  ////////////////////////////////////////////////////////////////////////////
  // instruction-cycle enable

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divReg <= 2'h0;
    end else if (divReg == 2'(`PWSD_TCY_CYC - 1)) begin
      divReg <= 2'h0;
    end else begin
      divReg <= divReg + 2'h1;
    end
  end

  assign tcyEn = (divReg == 2'(`PWSD_TCY_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;
  assign wrHit = wrFire && addrHit(awAddrReg) && wStrbReg[0];

  // address and data are caught independently, in either order
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      awAddrReg <= `PWSD_OFS_ASD;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddrReg <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wHeld <= 1'b0;
      wDataReg <= 32'h0000_0000;
      wStrbReg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wDataReg <= s_axi_wdata;
      wStrbReg <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PWSD_RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addrHit(awAddrReg) ? `PWSD_RESP_OKAY : `PWSD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  assign s_axi_arready = !s_axi_rvalid;
  assign arFire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PWSD_RESP_OKAY;
    end else if (arFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addrHit(s_axi_araddr) ? `PWSD_RESP_OKAY : `PWSD_RESP_SLVERR;
      s_axi_rdata <= 32'h0000_0000;
      unique case (s_axi_araddr)
        `PWSD_OFS_ASD: s_axi_rdata[7:0] <= {flagReg, asdReg};
        `PWSD_OFS_RDB: s_axi_rdata[7:0] <= rdbReg;
        `PWSD_OFS_UNIT: s_axi_rdata[7:0] <= unitReg;
        `PWSD_OFS_STEER: s_axi_rdata[3:0] <= steerReg;
        `PWSD_OFS_AUX: begin
          s_axi_rdata[`PWSD_AUX_SYNC] <= syncReg;
          s_axi_rdata[`PWSD_AUX_COND] <= cond;
          s_axi_rdata[`PWSD_AUX_RUN] <= (runReg == PWSD_RUN);
        end
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      asdReg <= `PWSD_RST_ASD;
    end else if (wrHit && awAddrReg == `PWSD_OFS_ASD) begin
      asdReg <= wDataReg[6:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdbReg <= `PWSD_RST_RDB;
    end else if (wrHit && awAddrReg == `PWSD_OFS_RDB) begin
      rdbReg <= wDataReg[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      unitReg <= `PWSD_RST_UNIT;
    end else if (wrHit && awAddrReg == `PWSD_OFS_UNIT) begin
      unitReg <= wDataReg[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      steerReg <= `PWSD_RST_STEER;
    end else if (wrHit && awAddrReg == `PWSD_OFS_STEER) begin
      steerReg <= wDataReg[`PWSD_STEER_HI:`PWSD_STEER_LO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncReg <= `PWSD_RST_AUX;
    end else if (wrHit && awAddrReg == `PWSD_OFS_AUX) begin
      syncReg <= wDataReg[`PWSD_AUX_SYNC];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shutdown condition and event flag

  // comparator two held between timer1 ticks when sync is on
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmp2SampReg <= 1'b0;
    end else if (src.t1Tick) begin
      cmp2SampReg <= src.cmp2Out;
    end
  end

  assign cmp2Eff = syncReg ? cmp2SampReg : src.cmp2Out;
  // a level, re-evaluated every cycle, never latched as an edge
  assign cond = srcCond(asdReg[`PWSD_ASD_SRC_HI:`PWSD_ASD_SRC_LO],
                        src.cmp1Out, cmp2Eff, !src.faultPinN);

  // set by the condition wins over any clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flagReg <= `PWSD_RST_FLAG;
    end else if (cond) begin
      flagReg <= 1'b1;
    end else if (wrHit && awAddrReg == `PWSD_OFS_ASD) begin
      flagReg <= wDataReg[`PWSD_ASD_FLAG];
    end else if (rdbReg[`PWSD_RDB_ARST]) begin
      flagReg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run state: resume only on a period boundary

  assign pwmOn = (unitReg[`PWSD_UNIT_MODE_HI:`PWSD_UNIT_MODE_HI-1] == `PWSD_MODE_PWM);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      runReg <= PWSD_SHUT;
    end else begin
      unique case (runReg)
        PWSD_RUN: begin
          if (cond || flagReg || !pwmOn) begin
            runReg <= PWSD_SHUT;
          end
        end
        PWSD_SHUT: begin
          if (periodStart && pwmOn && !cond && !flagReg) begin
            runReg <= PWSD_RUN;
          end
        end
      endcase
    end
  end

  // the raw condition bypasses the flops so pins go safe without a clock edge
  assign forceNow = cond || flagReg || (runReg == PWSD_SHUT);

  ////////////////////////////////////////////////////////////////////////////
  // dead-band and waveform routing

  pwsd_deadband dbUnitA (
    .mclk(mclk),
    .rst(rst),
    .tcyEn(tcyEn),
    .delayCount(rdbReg[`PWSD_RDB_DB_HI:`PWSD_RDB_DB_LO]),
    .sigIn(pwmIn),
    .sigOut(dbA)
  );

  pwsd_deadband dbUnitB (
    .mclk(mclk),
    .rst(rst),
    .tcyEn(tcyEn),
    .delayCount(rdbReg[`PWSD_RDB_DB_HI:`PWSD_RDB_DB_LO]),
    .sigIn(!pwmIn),
    .sigOut(dbB)
  );

  assign cfg = pwsd_cfg_t'(unitReg[`PWSD_UNIT_CFG_HI:`PWSD_UNIT_CFG_LO]);
  // mode bit 1 inverts pair a/c, bit 0 inverts pair b/d
  assign polVec = {unitReg[0], unitReg[1], unitReg[0], unitReg[1]};

  always_comb begin
    actVec = 4'h0;
    enVec = 4'h0;
    unique case (cfg)
      PWSD_CFG_SINGLE: begin
        actVec = {4{pwmIn}};
        enVec = steerReg;
      end
      PWSD_CFG_HALF: begin
        actVec = {2'b00, dbB, dbA};
        enVec = 4'h3;
      end
      PWSD_CFG_FWD: begin
        actVec = {pwmIn, 2'b00, 1'b1};
        enVec = 4'hF;
      end
      PWSD_CFG_REV: begin
        actVec = {2'b00, pwmIn, 1'b0} | 4'h4;
        enVec = 4'hF;
      end
    endcase
    if (!pwmOn) begin
      enVec = 4'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lvlReg <= 4'h0;
    end else begin
      lvlReg <= actVec ^ polVec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // safe states and pin drive

  assign safeLvl = {asdReg[`PWSD_ASD_BD_LO], asdReg[`PWSD_ASD_AC_LO],
                    asdReg[`PWSD_ASD_BD_LO], asdReg[`PWSD_ASD_AC_LO]};
  assign safeZ = {asdReg[`PWSD_ASD_BD_HI], asdReg[`PWSD_ASD_AC_HI],
                  asdReg[`PWSD_ASD_BD_HI], asdReg[`PWSD_ASD_AC_HI]};

  assign pins.level = forceNow ? safeLvl : lvlReg;
  // only pins already enabled are touched by a shutdown
  assign pins.oe = enVec & ~(safeZ & {4{forceNow}});

endmodule

//--- tb/pwsd_props.sv
// checker: bus answers and shutdown output states of the shutdown block
`include "pwsd_consts.svh"

module pwsd_props import pwsd_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [`PWSD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // waveform, sources and pins
  input wire logic periodStart,
  input pwsd_src_t src,
  input pwsd_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] asdShadow;
  logic [`PWSD_ADDR_W-1:0] pendAddr;
  logic [7:0] pendData;
  logic pendStrb;
  logic faultCond, safeAcOk, safeBdOk;

  ////////////////////////////////////////////////////////////////////////////
  // shadow of source and safe fields, committed on the block's own write edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      asdShadow <= 7'h00;
      pendAddr <= `PWSD_OFS_ASD;
      pendData <= 8'h00;
      pendStrb <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        pendAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        pendData <= s_axi_wdata[7:0];
        pendStrb <= s_axi_wstrb[0];
      end
      // both items held and no response out: the register is written now
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid && pendStrb
          && pendAddr == `PWSD_OFS_ASD) begin
        asdShadow <= pendData[6:0];
      end
    end
  end
  // only the fault pin is tracked: comparator sync would need internal state
  assign faultCond = asdShadow[6] && !src.faultPinN;
  assign safeAcOk = asdShadow[3] ? !(pins.oe[0] || pins.oe[2]) :
                    (!pins.oe[0] || pins.level[0] == asdShadow[2]) &&
                    (!pins.oe[2] || pins.level[2] == asdShadow[2]);
  assign safeBdOk = asdShadow[1] ? !(pins.oe[1] || pins.oe[3]) :
                    (!pins.oe[1] || pins.level[1] == asdShadow[0]) &&
                    (!pins.oe[3] || pins.level[3] == asdShadow[0]);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  safe_ac_a: assert property (faultCond |-> safeAcOk)
    else $error("pair a/c not in its safe state during fault");
  safe_bd_a: assert property (faultCond |-> safeBdOk)
    else $error("pair b/d not in its safe state during fault");
  quiet_boot_a: assert property (!rst && $past(rst) |-> pins.oe == 4'h0)
    else $error("pins driven right after reset");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");

  fault_c: cover property (faultCond);
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == `PWSD_RESP_SLVERR);
  resume_c: cover property (periodStart && |pins.oe);
endmodule

bind pwsd_top pwsd_props chk (.*);

//--- tb/pwsd_far_side.sv
// far side model: comparators, pulled-up fault pin and timer1 tick
module pwsd_far_side import pwsd_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // requested levels {fault, cmp2, cmp1}
  input wire logic [2:0] req,
  // sources toward the block
  output pwsd_src_t src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] tickCnt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tickCnt <= 4'h0;
      src <= '{cmp1Out: 1'b0, cmp2Out: 1'b0, faultPinN: 1'b1, t1Tick: 1'b0};
    end else begin
      tickCnt <= tickCnt + 4'h1;
      src.t1Tick <= (tickCnt == 4'hF);
      src.cmp1Out <= req[0];
      src.cmp2Out <= req[1];
      // pull-up wins when the fault driver lets go; a held level, never a pulse
      src.faultPinN <= !req[2];
    end
  end
endmodule

//--- tb/pwsd_top_tb.sv
// self-checking bench for the pwm shutdown, dead-band and steering block
`include "pwsd_consts.svh"
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin errCount++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end

module pwsd_top_tb import pwsd_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [`PWSD_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic pwmIn = 1'b0, periodStart = 1'b0;
  logic [4:0] cnt = 5'h00;
  logic [2:0] req = 3'h0;
  pwsd_src_t src;
  pwsd_pins_t pins;
  int errCount = 0, nTests = 0, highs = 0;
  logic [31:0] resetVals [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};

  pwsd_top dut (.*);
  pwsd_far_side far (.*);

  always #5 mclk = ~mclk;

  // 32-cycle period, 12 cycles of duty
  always @(posedge mclk) begin
    cnt <= cnt + 5'h01;
    periodStart <= (cnt == 5'h1F);
    pwmIn <= (cnt == 5'h1F) || (cnt < 5'h0B);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic timed_out();
    errCount++;
    $display("Error wait expected an answer seen none");
    tally_and_finish();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    timed_out();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    timed_out();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rsp);
    `CHK("write response", `PWSD_RESP_OKAY, rsp)
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rd, rsp);
    `CHK("register read", e, rd)
  endtask

  task automatic set_req(input logic [2:0] v);
    @(posedge mclk);
    req <= v;
    @(posedge mclk);
    #1;
  endtask

  task automatic at(input logic [4:0] c);
    for (int i = 0; i < 80; i++) begin
      @(posedge mclk);
      #1;
      if (cnt == c) return;
    end
    timed_out();
  endtask

  task automatic wait_tick();
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      #1;
      if (src.t1Tick) return;
    end
    timed_out();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 5; k++) rd_chk(8'(4 * k), resetVals[k]);
    axi_rd(8'h14, rd, rsp);
    `CHK("unmapped read", `PWSD_RESP_SLVERR, rsp)
    `CHK("unmapped data", 32'h0, rd)
    axi_wr(8'h14, 32'hFF, rsp);
    `CHK("unmapped write", `PWSD_RESP_SLVERR, rsp)
    // every source code against every source
    wr(8'h04, 32'h80);
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 3; k++) begin
        wr(8'h00, 32'(s << 4));
        set_req(3'(1 << k));
        axi_rd(8'h10, rd, rsp);
        `CHK("condition", (s[0] && k == 0) || (s[1] && k == 1) || (s[2] && k == 2), rd[8])
        set_req(3'h0);
      end
    end
    // single output with steering to a and b
    wr(8'h00, 32'h0);
    wr(8'h0C, 32'h3);
    wr(8'h08, 32'h0C);
    at(5'h00);
    at(5'h05);
    `CHK("steered enables", 4'h3, pins.oe)
    `CHK("steered duty", 2'h3, pins.level[1:0])
    wr(8'h08, 32'h0F);
    at(5'h05);
    `CHK("inverted duty", 2'h0, pins.level[1:0])
    at(5'h14);
    `CHK("inverted idle", 2'h3, pins.level[1:0])
    wr(8'h08, 32'h0C);
    // fault pin shutdown, a/c high, b/d released, firmware restart
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h46);
    set_req(3'h4);
    `CHK("shutdown enables", 4'h1, pins.oe)
    `CHK("shutdown level", 1'b1, pins.level[0])
    rd_chk(8'h00, 32'hC6);
    wr(8'h00, 32'h46);
    rd_chk(8'h00, 32'hC6);
    `CHK("held by level", 4'h1, pins.oe)
    set_req(3'h0);
    repeat (40) @(posedge mclk);
    #1;
    `CHK("stays shut", 4'h1, pins.oe)
    rd_chk(8'h00, 32'hC6);
    at(5'h01);
    wr(8'h00, 32'h46);
    `CHK("waits for period", 4'h1, pins.oe)
    rd_chk(8'h00, 32'h46);
    at(5'h00);
    at(5'h05);
    `CHK("resumed", 4'h3, pins.oe)
    // firmware forced shutdown with no source
    wr(8'h00, 32'h86);
    rd_chk(8'h00, 32'h86);
    `CHK("forced enables", 4'h1, pins.oe)
    // auto restart
    wr(8'h04, 32'h80);
    wr(8'h00, 32'h46);
    set_req(3'h4);
    rd_chk(8'h00, 32'hC6);
    set_req(3'h0);
    rd_chk(8'h00, 32'h46);
    at(5'h00);
    at(5'h05);
    `CHK("auto resumed", 4'h3, pins.oe)
    // half bridge, two instruction cycles of dead band
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h02);
    wr(8'h08, 32'h8C);
    at(5'h00);
    at(5'h03);
    `CHK("b falls at once", 1'b0, pins.level[1])
    at(5'h05);
    `CHK("a delayed", 1'b0, pins.level[0])
    at(5'h0B);
    `CHK("a active", 1'b1, pins.level[0])
    at(5'h11);
    `CHK("b delayed", 1'b0, pins.level[1])
    at(5'h18);
    `CHK("b active", 2'h2, pins.level[1:0])
    // dead band longer than the duty
    wr(8'h04, 32'h7F);
    at(5'h00);
    for (int i = 0; i < 32; i++) begin
      @(posedge mclk);
      #1;
      highs += int'(pins.level[0] === 1'b1);
    end
    `CHK("long dead band", 0, highs)
    // full bridge, forward then reverse
    wr(8'h08, 32'h4C);
    at(5'h05);
    `CHK("forward drive", 4'h9, pins.level)
    `CHK("forward enables", 4'hF, pins.oe)
    wr(8'h08, 32'hCC);
    at(5'h05);
    `CHK("reverse drive", 4'h6, pins.level)
    // comparator two held until the next timer1 tick; leaves the block shut
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h20);
    wait_tick();
    set_req(3'h2);
    axi_rd(8'h10, rd, rsp);
    `CHK("cmp2 before tick", 1'b0, rd[8])
    wait_tick();
    axi_rd(8'h10, rd, rsp);
    `CHK("cmp2 after tick", 1'b1, rd[8])
    tally_and_finish();
  end
endmodule
